// ---- spp_pkg.sv ----
/*
 * spp_pkg: constants, command codes, field positions and carrier types for
 * the serial program/verify port of a one-time-programmable controller.
 * Assumes nothing of its surroundings; imported whole by every module.
 */
package spp_pkg;

   // frame geometry
   localparam int unsigned CMD_BITS   = 6;
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned WORD_BITS  = 14;

   // command codes, lsb first
   localparam logic [5:0] CMD_LOAD_CFG  = 6'h00;
   localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
   localparam logic [5:0] CMD_READ_DATA = 6'h04;
   localparam logic [5:0] CMD_INCR_ADDR = 6'h06;
   localparam logic [5:0] CMD_PROG_BEG  = 6'h08;
   localparam logic [5:0] CMD_PROG_END  = 6'h0E;

   // frame counter marks (falling edges already seen in the frame)
   localparam logic [3:0] CNT_CMD_LAST  = 4'h5;
   localparam logic [3:0] CNT_DATA_FIRST = 4'h1;
   localparam logic [3:0] CNT_DATA_LAST = 4'hE;
   localparam logic [3:0] CNT_STOP      = 4'hF;

   // address space
   localparam logic [13:0] PC_RESET    = 14'h0000;
   localparam logic [13:0] PC_CFG_BASE = 14'h2000;
   localparam int unsigned PC_CFG_BIT  = 13;
   localparam int unsigned USER_DEPTH  = 2048;
   localparam int unsigned CFG_DEPTH   = 256;
   localparam logic [7:0]  CFG_WORD_IDX = 8'h07;
   localparam logic [10:0] USER_HALF   = 11'h200;
   localparam logic [10:0] USER_QUART3 = 11'h400;
   localparam logic [10:0] MASK_05K    = 11'h1FF;
   localparam logic [10:0] MASK_1K     = 11'h3FF;
   localparam logic [10:0] MASK_2K     = 11'h7FF;

   // configuration word layout and erased value
   localparam logic [13:0] CFG_ERASED = 14'h3FFF;
   localparam logic [13:0] WORD_ZERO  = 14'h0000;
   localparam int unsigned CFG_CP_HI  = 5;
   localparam int unsigned CFG_CP_LO  = 4;
   localparam int unsigned CFG_PWRT_N = 3;
   localparam int unsigned CFG_WDT_EN = 2;
   localparam int unsigned CFG_OSC_HI = 1;
   localparam int unsigned CFG_OSC_LO = 0;

   typedef enum logic [1:0] {
      VAR_05K = 2'b00,
      VAR_1K  = 2'b01,
      VAR_2K  = 2'b10
   } spp_variant_e;

   // memory size of this build
   localparam spp_variant_e SPP_VARIANT = VAR_2K;

   typedef enum logic {
      PH_CMD  = 1'b0,
      PH_DATA = 1'b1
   } spp_phase_e;

   // command and word handed from the link domain to the core domain
   typedef struct packed {
      logic [5:0]  cmd;
      logic [13:0] word;
   } spp_xfer_s;

endpackage

// ---- spp_link.sv ----
/*
 * spp_link: serial frame engine clocked by the programmer's serial clock.
 * Assumes the serial clock stands still between frames and that link_rst_n
 * is low whenever the device is outside program/verify mode.
 */
`timescale 1ns/1ps
module spp_link
   import spp_pkg::*;
(
   input  wire logic        serial_clock_pin,
   input  wire logic        link_rst_n,
   input  wire logic        serial_data_in,
   input  wire logic [13:0] rd_word,
   output spp_xfer_s        xfer,
   output logic             xfer_tgl,
   output logic             serial_data_out,
   output logic             serial_data_oe
);

   typedef struct packed {
      spp_phase_e  phase;
      logic [3:0]  cnt;
      logic [5:0]  cmd_sh;
      logic [13:0] word_sh;
      logic [13:0] rd_hold;
      spp_xfer_s   xfer;
      logic        tgl;
   } spp_link_s;

   spp_link_s  r;
   spp_link_s  nxt;
   logic       out_r;
   logic       oe_r;
   logic [3:0] bit_idx;
   logic [5:0] code;

   function automatic logic has_frame(input logic [5:0] c);
      return (c == CMD_LOAD_CFG) || (c == CMD_LOAD_DATA) || (c == CMD_READ_DATA);
   endfunction

   // next state, all bits taken on the falling edge
   always_comb
   begin
      nxt  = r;
      code = {serial_data_in, r.cmd_sh[5:1]};
      unique case (r.phase)
         PH_CMD:
         begin
            nxt.cmd_sh = code;
            nxt.cnt    = r.cnt + 4'h1;
            if (r.cnt == CNT_CMD_LAST)
            begin
               nxt.cnt      = 4'h0;
               nxt.xfer.cmd = code;
               if (has_frame(code))
                  nxt.phase = PH_DATA;
               else
                  nxt.tgl = ~r.tgl;
            end
         end
         PH_DATA:
         begin
            nxt.cnt = r.cnt + 4'h1;
            // read word is still from the last command; held through frame
            if (r.cnt == 4'h0)
               nxt.rd_hold = rd_word;
            if (r.cnt >= CNT_DATA_FIRST && r.cnt <= CNT_DATA_LAST)
               nxt.word_sh = {serial_data_in, r.word_sh[13:1]};
            if (r.cnt == CNT_STOP)
            begin
               nxt.cnt       = 4'h0;
               nxt.phase     = PH_CMD;
               nxt.xfer.word = r.word_sh;
               nxt.tgl       = ~r.tgl;
            end
         end
      endcase
   end

   // link state; cleared whenever the mode is left
   always_ff @(negedge serial_clock_pin or negedge link_rst_n)
   begin
      if (!link_rst_n)
         r <= '0;
      else
         r <= nxt;
   end

   assign bit_idx = 4'(r.cnt - 4'h1);

   // read output: the pin turns only on rising edges, or drops low when the mode is left
   always_ff @(posedge serial_clock_pin or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         out_r <= 1'b0;
         oe_r  <= 1'b0;
      end
      else if (r.phase == PH_DATA && r.xfer.cmd == CMD_READ_DATA &&
               r.cnt >= CNT_DATA_FIRST && r.cnt <= CNT_DATA_LAST)
      begin
         oe_r  <= 1'b1;
         out_r <= r.rd_hold[bit_idx];
      end
      else
      begin
         oe_r  <= 1'b0;
         out_r <= 1'b0;
      end
   end

   assign xfer            = r.xfer;
   assign xfer_tgl        = r.tgl;
   assign serial_data_out = out_r;
   assign serial_data_oe  = oe_r;

endmodule

// ---- spp_port.sv ----
/*
 * spp_port: program/verify port top. Holds program counter, the one-time-
 * programmable user and configuration arrays, code protection and the
 * decoded configuration fields.
 * Assumes: serial_clock_pin is the programmer's clock, stopped between
 * frames; mode_entry_high_voltage_pin is a clean level that is high while
 * the entry pin sits at programming voltage.
 */
`timescale 1ns/1ps
module spp_port
   import spp_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic serial_clock_pin,
   input  wire logic serial_data_in,
   output logic      serial_data_out,
   output logic      serial_data_oe,
   input  wire logic mode_entry_high_voltage_pin,
   output logic      prog_mode,
   output logic      core_reset_n,
   output logic      io_hiz,
   output logic      program_active,
   output logic      protect_sel_hi,
   output logic      protect_sel_lo,
   output logic      powerup_delay_enable_n,
   output logic      watchdog_enable,
   output logic      osc_select_hi,
   output logic      osc_select_lo
);

   typedef struct packed {
      logic        ent_s1;
      logic        ent_s2;
      logic        ev_s1;
      logic        ev_s2;
      logic        ev_s3;
      logic        in_mode;
      logic [13:0] pc;
      logic        loaded;
      logic [13:0] load_word;
      logic        prog_active;
      logic [13:0] rd_word;
      logic [13:0] cfg_word;
      logic        core_reset_n;
      logic        io_hiz;
   } spp_core_s;

   spp_core_s   r;
   spp_core_s   nxt;

   // one-time-programmable arrays; bits only go from one to zero, except at reset, which erases all to one
   logic [13:0] user_mem [0:USER_DEPTH-1];
   logic [13:0] cfg_mem  [0:CFG_DEPTH-1];

   spp_xfer_s   xfer;
   logic        xfer_tgl;
   logic        link_out;
   logic        link_oe;

   logic        wr_user;
   logic        wr_cfg;
   logic [10:0] wr_uidx;
   logic [7:0]  wr_cidx;
   logic [13:0] wr_data;
   logic        ev;
   logic [10:0] cur_uidx;
   logic [7:0]  cur_cidx;
   logic        cur_prot;

   function automatic logic [10:0] user_idx(input logic [13:0] pc);
      logic [10:0] m;
      m = MASK_2K;
      unique case (SPP_VARIANT)
         VAR_05K: m = MASK_05K;
         VAR_1K:  m = MASK_1K;
         VAR_2K:  m = MASK_2K;
      endcase
      return pc[10:0] & m;
   endfunction

   function automatic logic prot(input logic [10:0] a, input logic [13:0] cw);
      logic [1:0] cp;
      cp = {cw[CFG_CP_HI], cw[CFG_CP_LO]};
      unique case (cp)
         2'b00: return 1'b1;
         // upper half or three quarters on the larger parts
         2'b01: return (SPP_VARIANT != VAR_05K) && (a >= USER_HALF);
         // upper half only on the largest part; elsewhere a do-not-use code
         2'b10: return (SPP_VARIANT == VAR_2K) && (a >= USER_QUART3);
         2'b11: return 1'b0;
      endcase
   endfunction

   // frame engine on the programmer's clock
   spp_link u_link (
      .serial_clock_pin (serial_clock_pin),
      .link_rst_n       (mode_entry_high_voltage_pin),
      .serial_data_in   (serial_data_in),
      .rd_word          (r.rd_word),
      .xfer             (xfer),
      .xfer_tgl         (xfer_tgl),
      .serial_data_out  (link_out),
      .serial_data_oe   (link_oe)
   );

   // current location decode
   // alias configuration space
   assign cur_cidx = r.pc[7:0];
   assign cur_uidx = user_idx(r.pc);
   assign cur_prot = prot(cur_uidx, r.cfg_word);

   // a completed command or frame shows up as a toggle edge here
   assign ev = r.ev_s2 ^ r.ev_s3;

   // core next state
   always_comb
   begin
      nxt     = r;
      wr_user = 1'b0;
      wr_cfg  = 1'b0;
      wr_uidx = cur_uidx;
      wr_cidx = cur_cidx;
      wr_data = WORD_ZERO;

      // pin and toggle synchronisers
      // entry pin sampled
      nxt.ent_s1 = mode_entry_high_voltage_pin;
      nxt.ent_s2 = r.ent_s1;
      nxt.ev_s1  = xfer_tgl;
      nxt.ev_s2  = r.ev_s1;
      nxt.ev_s3  = r.ev_s2;
      nxt.in_mode = r.ent_s2;

      nxt.core_reset_n = ~r.ent_s2;
      nxt.io_hiz       = r.ent_s2;

      nxt.cfg_word = cfg_mem[CFG_WORD_IDX];

      if (r.pc[PC_CFG_BIT])
         nxt.rd_word = cfg_mem[cur_cidx];
      else if (cur_prot)
         nxt.rd_word = WORD_ZERO;
      else
         nxt.rd_word = user_mem[cur_uidx];

      if (!r.in_mode)
      begin
         nxt.pc          = PC_RESET;
         nxt.loaded      = 1'b0;
         nxt.prog_active = 1'b0;
      end
      else if (ev)
      begin
         // the link holds xfer steady for far longer than the sync delay
         unique case (xfer.cmd)
            CMD_LOAD_CFG:
            begin
               nxt.pc        = PC_CFG_BASE;
               nxt.load_word = xfer.word;
               nxt.loaded    = 1'b1;
            end
            CMD_LOAD_DATA:
            begin
               nxt.load_word = xfer.word;
               nxt.loaded    = 1'b1;
            end
            CMD_READ_DATA:
            begin
               nxt.loaded = r.loaded;
            end
            CMD_INCR_ADDR:
            begin
               nxt.pc = {r.pc[PC_CFG_BIT], 13'(r.pc[12:0] + 13'h0001)};
            end
            CMD_PROG_BEG:
            begin
               if (r.loaded)
               begin
                  nxt.prog_active = 1'b1;
                  nxt.loaded      = 1'b0;
                  wr_data         = r.load_word;
                  if (r.pc[PC_CFG_BIT])
                     wr_cfg = 1'b1;
                  else
                     wr_user = ~cur_prot;
               end
            end
            CMD_PROG_END:
            begin
               nxt.prog_active = 1'b0;
            end
            default:
            begin
               nxt.pc = r.pc;
            end
         endcase
      end
   end

   // core state register
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         r              <= '0;
         r.core_reset_n <= 1'b1;
         r.cfg_word     <= CFG_ERASED;
      end
      else
      begin
         r <= nxt;
      end
   end

   // array writes: programming can only clear bits, as in the real cell
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < USER_DEPTH; i++)
            user_mem[i] <= CFG_ERASED;
         for (int j = 0; j < CFG_DEPTH; j++)
            cfg_mem[j] <= CFG_ERASED;
      end
      else
      begin
         if (wr_user)
            user_mem[wr_uidx] <= user_mem[wr_uidx] & wr_data;
         if (wr_cfg)
            cfg_mem[wr_cidx] <= cfg_mem[wr_cidx] & wr_data;
      end
   end

   // write data is the word latched at the last load, not the live xfer
   // (a read frame in between would otherwise overwrite the live word)

   // outputs straight from flops
   assign serial_data_out        = link_out;
   assign serial_data_oe         = link_oe;
   assign prog_mode              = r.in_mode;
   assign core_reset_n           = r.core_reset_n;
   assign io_hiz                 = r.io_hiz;
   assign program_active         = r.prog_active;
   assign protect_sel_hi         = r.cfg_word[CFG_CP_HI];
   assign protect_sel_lo         = r.cfg_word[CFG_CP_LO];
   assign powerup_delay_enable_n = r.cfg_word[CFG_PWRT_N];
   assign watchdog_enable        = r.cfg_word[CFG_WDT_EN];
   assign osc_select_hi          = r.cfg_word[CFG_OSC_HI];
   assign osc_select_lo          = r.cfg_word[CFG_OSC_LO];

endmodule

// ---- spp_port_monitor.sv ----
/*
 * spp_port_monitor: port checks for spp_port, bound to it below.
 * Assumes the serial clock stands still between frames.
 */
`timescale 1ns/1ps
module spp_port_monitor
   import spp_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic serial_clock_pin,
   input  wire logic serial_data_out,
   input  wire logic serial_data_oe,
   input  wire logic mode_entry_high_voltage_pin,
   input  wire logic prog_mode,
   input  wire logic core_reset_n,
   input  wire logic io_hiz,
   input  wire logic program_active,
   input  wire logic protect_sel_hi,
   input  wire logic protect_sel_lo,
   input  wire logic powerup_delay_enable_n,
   input  wire logic watchdog_enable,
   input  wire logic osc_select_hi,
   input  wire logic osc_select_lo
);
   // configuration outputs gathered for compact checks
   logic [5:0] cfg_bits;
   assign cfg_bits = {protect_sel_hi, protect_sel_lo, powerup_delay_enable_n,
                      watchdog_enable, osc_select_hi, osc_select_lo};

   // read frame: fourteen driven rising edges, then a quiet pin
   sequence s_drive14;
      serial_data_oe [*8] ##1 serial_data_oe [*6];
   endsequence
   sequence s_quiet;
      !serial_data_oe && !serial_data_out;
   endsequence

   a_entry_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(mode_entry_high_voltage_pin) |-> ##[1:4] prog_mode)
      else $error("mode not entered after pin rise");
   a_core_held: assert property (@(posedge mclk) disable iff (!rst_n)
      prog_mode [*3] |-> !core_reset_n && io_hiz)
      else $error("core not held in reset while in mode");
   a_exit_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(mode_entry_high_voltage_pin) |-> ##[1:4] !prog_mode)
      else $error("mode not left after pin fall");
   a_exit_release: assert property (@(posedge mclk) disable iff (!rst_n)
      !prog_mode [*3] |-> core_reset_n && !io_hiz && !program_active)
      else $error("core still held outside mode");
   a_pin_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
      !mode_entry_high_voltage_pin |-> !serial_data_oe && !serial_data_out)
      else $error("data pin driven outside mode");
   a_active_mode: assert property (@(posedge mclk) disable iff (!rst_n)
      program_active |-> prog_mode)
      else $error("programming active outside mode");
   a_cfg_reset: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> cfg_bits == 6'h3F && !prog_mode)
      else $error("configuration outputs not erased after reset");
   a_cfg_steady: assert property (@(posedge mclk) disable iff (!rst_n)
      !prog_mode [*3] |=> $stable(cfg_bits))
      else $error("configuration outputs moved outside mode");
   a_read_window: assert property (@(posedge serial_clock_pin)
      disable iff (!mode_entry_high_voltage_pin)
      $rose(serial_data_oe) |-> s_drive14 ##1 s_quiet)
      else $error("read frame drive window wrong");
endmodule

bind spp_port spp_port_monitor mon (
   .mclk(mclk), .rst_n(rst_n), .serial_clock_pin(serial_clock_pin),
   .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
   .mode_entry_high_voltage_pin(mode_entry_high_voltage_pin),
   .prog_mode(prog_mode), .core_reset_n(core_reset_n), .io_hiz(io_hiz),
   .program_active(program_active), .protect_sel_hi(protect_sel_hi),
   .protect_sel_lo(protect_sel_lo), .powerup_delay_enable_n(powerup_delay_enable_n),
   .watchdog_enable(watchdog_enable), .osc_select_hi(osc_select_hi),
   .osc_select_lo(osc_select_lo)
);

// ---- spp_programmer.sv ----
/*
 * spp_programmer: behavioural external programmer driving the serial port.
 * Assumes the bench resolves the data line from this value and the device.
 */
`timescale 1ns/1ps
module spp_programmer
   import spp_pkg::*;
(
   output logic      serial_clock_pin,
   output logic      drive_val,
   output logic      mode_entry_high_voltage_pin,
   input  wire logic line_level
);
   localparam realtime HALF = 62.5;
   localparam realtime GAP  = 100.0; // twelve and a half core cycles
   logic released;

   // idle: clock, data and entry pin low
   initial
   begin
      serial_clock_pin = 1'b0;
      drive_val = 1'b0;
      mode_entry_high_voltage_pin = 1'b0;
      released = 1'b0;
   end

   // one cycle; a released line shows a changing pattern, never a stale bit
   task automatic tick(input logic b, output logic s);
      serial_clock_pin = 1'b1;
      #1;
      drive_val = released ? ~drive_val : b;
      #(HALF - 1.0);
      serial_clock_pin = 1'b0;
      s = line_level;
      #HALF;
   endtask

   // clock and data low while raising
   task automatic enter();
      serial_clock_pin = 1'b0;
      drive_val = 1'b0;
      #GAP mode_entry_high_voltage_pin = 1'b1;
      #GAP;
   endtask

   task automatic leave();
      mode_entry_high_voltage_pin = 1'b0;
      #GAP;
   endtask

   // six bits lsb first, then gap
   task automatic cmd(input logic [5:0] c);
      logic s;
      for (int i = 0; i < 6; i++)
         tick(c[i], s);
      #GAP;
   endtask

   // zero start, fourteen bits, zero stop
   task automatic load(input logic [5:0] c, input logic [13:0] w);
      logic [15:0] f;
      logic        s;
      f = {1'b0, w, 1'b0};
      cmd(c);
      for (int i = 0; i < 16; i++)
         tick(f[i], s);
      #GAP;
   endtask

   // line released for the whole frame; bits taken on falling edges
   task automatic read(output logic [13:0] w);
      logic [15:0] f;
      cmd(CMD_READ_DATA);
      released = 1'b1;
      for (int i = 0; i < 16; i++)
         tick(1'b0, f[i]);
      released = 1'b0;
      drive_val = 1'b0;
      w = f[14:1];
      #GAP;
   endtask
endmodule

// ---- spp_port_bench.sv ----
/*
 * spp_port_bench: self-checking bench for spp_port with a programmer model.
 * Assumes the 2K build and the AND-on-program cell behaviour.
 */
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("mismatch at %0t: got %h want %h", $time, got, exp); \
      end \
   end
module spp_port_bench
   import spp_pkg::*;
;
   typedef struct packed {
      logic [1:0]  incs;
      logic [13:0] word;
      logic [13:0] exp_word;
   } spp_row_s;

   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        serial_clock_pin, prg_drive, mode_entry_high_voltage_pin;
   logic        serial_data_in, serial_data_out, serial_data_oe;
   logic        prog_mode, core_reset_n, io_hiz, program_active;
   logic        protect_sel_hi, protect_sel_lo, powerup_delay_enable_n;
   logic        watchdog_enable, osc_select_hi, osc_select_lo;
   logic [5:0]  cfg_vec;
   logic [2:0]  mode_vec;
   logic [13:0] rd;
   int          fail_count = 0;
   int          samples_checked = 0;
   spp_row_s    rows [3] = '{'{2'd0, 14'h1234, 14'h1234},
                             '{2'd0, 14'h3F0F, 14'h1204},
                             '{2'd1, 14'h2AAA, 14'h2AAA}};

   // the data wire: device when enabled, else the programmer
   assign serial_data_in = serial_data_oe ? serial_data_out : prg_drive;
   assign cfg_vec = {protect_sel_hi, protect_sel_lo, powerup_delay_enable_n,
                     watchdog_enable, osc_select_hi, osc_select_lo};
   assign mode_vec = {prog_mode, core_reset_n, io_hiz};

   spp_programmer prg (
      .serial_clock_pin(serial_clock_pin), .drive_val(prg_drive),
      .mode_entry_high_voltage_pin(mode_entry_high_voltage_pin),
      .line_level(serial_data_in)
   );

   spp_port uut (
      .mclk(mclk), .rst_n(rst_n), .serial_clock_pin(serial_clock_pin),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe),
      .mode_entry_high_voltage_pin(mode_entry_high_voltage_pin),
      .prog_mode(prog_mode), .core_reset_n(core_reset_n), .io_hiz(io_hiz),
      .program_active(program_active), .protect_sel_hi(protect_sel_hi),
      .protect_sel_lo(protect_sel_lo), .powerup_delay_enable_n(powerup_delay_enable_n),
      .watchdog_enable(watchdog_enable), .osc_select_hi(osc_select_hi),
      .osc_select_lo(osc_select_lo)
   );

   // core clock, 8 ns period
   initial
   begin
      forever #4 mclk = ~mclk;
   end

   task wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // bounded wait for the mode flag, then a settling margin
   task automatic wait_mode(input logic v);
      int n;
      n = 0;
      while (prog_mode !== v && n < 20)
      begin
         @(posedge mclk);
         n++;
      end
      if (n == 20)
      begin
         fail_count++;
         wrap_up();
      end
      repeat (4) @(posedge mclk);
   endtask

   task automatic prog(input logic [13:0] w);
      prg.load(CMD_LOAD_DATA, w);
      prg.cmd(CMD_PROG_BEG);
      prg.cmd(CMD_PROG_END);
   endtask

   // hang guard
   initial
   begin
      repeat (100000) @(posedge mclk);
      fail_count++;
      wrap_up();
   end

   // main sequence: reset and entry checks, then rows, then hand-written cases
   initial
   begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHECK_EQ(cfg_vec, 6'h3F)
      `CHECK_EQ(mode_vec, 3'b010)
      prg.enter();
      wait_mode(1'b1);
      `CHECK_EQ(mode_vec, 3'b101)
      prg.read(rd);
      `CHECK_EQ(rd, 14'h3FFF)
      foreach (rows[i])
      begin
         repeat (rows[i].incs) prg.cmd(CMD_INCR_ADDR);
         prog(rows[i].word);
         prg.read(rd);
         `CHECK_EQ(rd, rows[i].exp_word)
      end
      prg.cmd(6'h3F);
      prg.cmd(6'h0A);
      prg.read(rd);
      `CHECK_EQ(rd, 14'h2AAA)
      prg.load(CMD_LOAD_CFG, 14'h0005);
      prg.cmd(CMD_PROG_BEG);
      `CHECK_EQ(program_active, 1'b1)
      prg.cmd(CMD_PROG_END);
      `CHECK_EQ(program_active, 1'b0)
      prg.read(rd);
      `CHECK_EQ(rd, 14'h0005)
      repeat (7) prg.cmd(CMD_INCR_ADDR);
      prog(14'h0086);
      prg.read(rd);
      `CHECK_EQ(rd, 14'h0086)
      repeat (256) prg.cmd(CMD_INCR_ADDR);
      prg.read(rd);
      `CHECK_EQ(rd, 14'h0086)
      prg.cmd(CMD_PROG_BEG);
      `CHECK_EQ(program_active, 1'b0)
      prg.cmd(CMD_PROG_END);
      prg.leave();
      wait_mode(1'b0);
      `CHECK_EQ(mode_vec, 3'b010)
      `CHECK_EQ(cfg_vec, 6'h06)
      prg.enter();
      wait_mode(1'b1);
      prg.read(rd);
      `CHECK_EQ(rd, 14'h0000)
      prg.load(CMD_LOAD_CFG, 14'h3FFF);
      prg.read(rd);
      `CHECK_EQ(rd, 14'h0005)
      wrap_up();
   end
endmodule
